// ### rtl/scs_scanner.v
// Twenty-four channel status scanner: remote channel latches, word counter, group
// multiplexer, and control-side group latches with clear and test controls.
//
// The address map and the address-and-strobe port were decided locally.
`include "scs_defs.vh"
`default_nettype none

// What this block does
// - Clear pushbutton drives clear line low remotely
// - Control test forces all group latches low
// - Low status bit turns indicator on
// - After test, groups return one per update
// - Low channel input resets its latch
// - Latch stays low after closure removed
// - Low clear line sets all channel latches
// - Strobe becomes low pulse; counter steps
// - Two-bit count goes to host and mux
// - Only one six-bit group is transmitted
// - Count selects channels 1-6 through 19-24
// - Latch output drives its remote indicator
// - Remote test forces all remote indicators on
// - Non-latching channel feeds raw input to the mux instead
// - Fourth word clocks one selected group latch
// - Four cycles refresh all twenty-four channels
// - Held closure reactivates after clear release
// - Remote test affects remote indicators only
module scs_scanner (
   input wire REF_CLK,
   input wire RSTN,
   input wire [23:0] CHAN_IN_N,
   input wire CLEAR_PUSHBUTTON_N,
   input wire CONTROL_TEST_PUSHBUTTON_N,
   input wire REMOTE_TEST_N,
   input wire CYCLE_DONE_STROBE,
   input wire [5:0] RX_GROUP_DATA,
   input wire WORD_ARRIVAL_STROBE_N,
   input wire WORD_SELECT_LOW,
   input wire WORD_SELECT_HIGH,
   input wire THREE_WORDS_RECEIVED_N,
   output reg CLEAR_LINE_N,
   output reg [5:0] GROUP_DATA_BITS,
   output reg [1:0] WORD_COUNTER,
   output reg SHAPED_PULSE_N,
   output reg [23:0] REMOTE_LED_N,
   output reg [23:0] CONTROL_LED_N,
   output reg [23:0] ALARM_DRIVE,
   input wire [7:0] REG_ADDR,
   input wire [31:0] REG_WDATA,
   input wire REG_WRITE,
   input wire REG_READ,
   output reg [31:0] REG_RDATA
);

   // ****************************************
   // Helpers
   // ****************************************

   // Picks the six-bit group of a 24-bit channel vector addressed by a two-bit index.
   function [5:0] group_of;
      input [23:0] vec;
      input [1:0] idx;
      begin
         case (idx)
            2'h0: group_of = vec[5:0];
            2'h1: group_of = vec[11:6];
            2'h2: group_of = vec[17:12];
            default: group_of = vec[23:18];
         endcase
      end
   endfunction

   // Returns the vector with the addressed six-bit group replaced.
   function [23:0] group_put;
      input [23:0] vec;
      input [1:0] idx;
      input [5:0] grp;
      reg [23:0] tmp;
      begin
         tmp = vec;
         case (idx)
            2'h0: tmp[5:0] = grp;
            2'h1: tmp[11:6] = grp;
            2'h2: tmp[17:12] = grp;
            default: tmp[23:18] = grp;
         endcase
         group_put = tmp;
      end
   endfunction

   // ****************************************
   // Input synchronisation
   // ****************************************

   wire [37:0] sync_in;
   wire [37:0] sync_out;

   assign sync_in = {THREE_WORDS_RECEIVED_N, WORD_SELECT_HIGH, WORD_SELECT_LOW,
                     WORD_ARRIVAL_STROBE_N, RX_GROUP_DATA, CYCLE_DONE_STROBE,
                     REMOTE_TEST_N, CONTROL_TEST_PUSHBUTTON_N, CLEAR_PUSHBUTTON_N,
                     CHAN_IN_N};

   scs_sync #(
      .WIDTH(`SCS_SYNC_WIDTH),
      .RESET_VAL(`SCS_RST_SYNC)
   ) u_sync (
      .clk(REF_CLK),
      .rstn(RSTN),
      .din(sync_in),
      .dout(sync_out)
   );

   wire [23:0] chan_n;
   wire clear_btn_n;
   wire ctrl_test_n;
   wire remote_test_n;
   wire cycle_done;
   wire [5:0] rx_data;
   wire arrival_n;
   wire [1:0] word_sel;
   wire three_words_n;

   assign chan_n = sync_out[23:0];
   assign clear_btn_n = sync_out[24];
   assign ctrl_test_n = sync_out[25];
   assign remote_test_n = sync_out[26];
   assign cycle_done = sync_out[27];
   assign rx_data = sync_out[33:28];
   assign arrival_n = sync_out[34];
   assign word_sel = sync_out[36:35];
   assign three_words_n = sync_out[37];

   // ****************************************
   // Registers
   // ****************************************

   reg [23:0] nonlatch;
   reg [23:0] chan_latch;
   reg [23:0] group_latch;
   reg cycle_done_d;
   reg arrival_d;
   reg [2:0] shaper_cnt;
   reg [23:0] mux_src;
   reg [31:0] next_rdata;

   // Reload value of the pulse-width counter, cut to the counter's width on use.
   localparam [31:0] SHAPER_LOAD = `SCS_SHAPER_CYCLES - 1;

   wire strobe_rise;
   wire arrival_fall;
   wire shaper_start;

   assign strobe_rise = cycle_done & ~cycle_done_d;
   assign arrival_fall = arrival_d & ~arrival_n;
   assign shaper_start = strobe_rise & SHAPED_PULSE_N;

   // ****************************************
   // Front panel clear line
   // ****************************************

   // The clear line follows the pushbutton and is the clear seen by the channel latches.
   always @(posedge REF_CLK) begin
      if (!RSTN) begin
         CLEAR_LINE_N <= 1'b1;
      end else begin
         CLEAR_LINE_N <= clear_btn_n;
      end
   end

   // ****************************************
   // Remote channel latches
   // ****************************************

   // Clear sets every latch and wins over a closure; a closure resets only its channel.
   always @(posedge REF_CLK) begin
      if (!RSTN) begin
         chan_latch <= `SCS_RST_LATCHES;
      end else if (!CLEAR_LINE_N) begin
         chan_latch <= `SCS_RST_LATCHES;
      end else begin
         chan_latch <= chan_latch & chan_n;
      end
   end

   // ****************************************
   // Strobe pulse shaper and word counter
   // ****************************************

   // Each cycle-done edge starts one fixed-width low pulse; further edges during the
   // pulse are absorbed, so the counter steps exactly once per pulse.
   always @(posedge REF_CLK) begin
      if (!RSTN) begin
         cycle_done_d <= 1'b0;
         shaper_cnt <= 3'h0;
         SHAPED_PULSE_N <= 1'b1;
         WORD_COUNTER <= 2'h0;
      end else begin
         cycle_done_d <= cycle_done;
         if (shaper_start) begin
            SHAPED_PULSE_N <= 1'b0;
            shaper_cnt <= SHAPER_LOAD[2:0];
            WORD_COUNTER <= WORD_COUNTER + 2'h1;
         end else if (!SHAPED_PULSE_N) begin
            if (shaper_cnt == 3'h0) begin
               SHAPED_PULSE_N <= 1'b1;
            end else begin
               shaper_cnt <= shaper_cnt - 3'h1;
            end
         end
      end
   end

   // ****************************************
   // Group multiplexer and remote indicators
   // ****************************************

   // Non-latching channels present their raw input in place of the latch output.
   always @* begin
      mux_src = (chan_latch & ~nonlatch) | (chan_n & nonlatch);
   end

   always @(posedge REF_CLK) begin
      if (!RSTN) begin
         GROUP_DATA_BITS <= 6'h3F;
         REMOTE_LED_N <= 24'hFFFFFF;
      end else begin
         GROUP_DATA_BITS <= group_of(mux_src, WORD_COUNTER);
         if (!remote_test_n) begin
            REMOTE_LED_N <= 24'h000000;
         end else begin
            REMOTE_LED_N <= chan_latch;
         end
      end
   end

   // ****************************************
   // Control side group latches
   // ****************************************

   // Only the fourth word of a cycle updates a group, so all 24 take four cycles.
   always @(posedge REF_CLK) begin
      if (!RSTN) begin
         arrival_d <= 1'b1;
         group_latch <= `SCS_RST_GROUPS;
      end else begin
         arrival_d <= arrival_n;
         if (!ctrl_test_n) begin
            group_latch <= 24'h000000;
         end else if (arrival_fall && !three_words_n) begin
            group_latch <= group_put(group_latch, word_sel, rx_data);
         end
      end
   end

   // A low status bit lights the indicator and turns the alarm driver on.
   always @(posedge REF_CLK) begin
      if (!RSTN) begin
         CONTROL_LED_N <= 24'hFFFFFF;
         ALARM_DRIVE <= 24'h000000;
      end else begin
         CONTROL_LED_N <= group_latch;
         ALARM_DRIVE <= ~group_latch;
      end
   end

   // ****************************************
   // Register port
   // ****************************************

   always @(posedge REF_CLK) begin
      if (!RSTN) begin
         nonlatch <= `SCS_RST_NONLATCH;
      end else if (REG_WRITE && REG_ADDR == `SCS_ADDR_NONLATCH) begin
         nonlatch <= REG_WDATA[23:0];
      end
   end

   always @* begin
      next_rdata = 32'h00000000;
      case (REG_ADDR)
         `SCS_ADDR_NONLATCH: next_rdata = {8'h00, nonlatch};
         `SCS_ADDR_LATCHES: next_rdata = {8'h00, chan_latch};
         `SCS_ADDR_GROUPS: next_rdata = {8'h00, group_latch};
         `SCS_ADDR_STATUS: next_rdata = {26'h0000000, remote_test_n, ctrl_test_n,
                                         CLEAR_LINE_N, SHAPED_PULSE_N, WORD_COUNTER};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Read data stand only in the cycle after the read strobe.
   always @(posedge REF_CLK) begin
      if (!RSTN) begin
         REG_RDATA <= 32'h00000000;
      end else if (REG_READ) begin
         REG_RDATA <= next_rdata;
      end else begin
         REG_RDATA <= 32'h00000000;
      end
   end

endmodule // scs_scanner

`default_nettype wire

// ### rtl/scs_defs.vh
// Constants for the status channel scanner: offsets, reset values and timing counts.
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// ****************************************
// Sizes
// ****************************************
`define SCS_CHANNELS 24
`define SCS_GROUP_BITS 6
`define SCS_SYNC_WIDTH 38

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SCS_ADDR_NONLATCH 8'h00
`define SCS_ADDR_LATCHES 8'h04
`define SCS_ADDR_GROUPS 8'h08
`define SCS_ADDR_STATUS 8'h0C

// ****************************************
// Reset values
// ****************************************
`define SCS_RST_NONLATCH 24'h000000
`define SCS_RST_LATCHES 24'hFFFFFF
`define SCS_RST_GROUPS 24'hFFFFFF
`define SCS_RST_SYNC 38'h27F7FFFFFF

// ****************************************
// Timing: strobe pulse shaper width
// ****************************************
`define SCS_CLK_PERIOD_NS 8
`define SCS_SHAPER_NS 32
`define SCS_SHAPER_CYCLES ((`SCS_SHAPER_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)

`endif

// ### rtl/scs_sync.v
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`default_nettype none

module scs_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire clk,
   input wire rstn,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer i;

   // The first stage feeds only the second stage.
   always @(posedge clk) begin
      if (!rstn) begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
               dout[i] <= stage3[i];
            end
         end
      end
   end

endmodule // scs_sync

`default_nettype wire

// ### rtl/scs_unused_placeholder.v
// This file holds no logic.

// ### verification/scs_props.sv
// Port checker for the status channel scanner.
`default_nettype none
module scs_props (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic CLEAR_PUSHBUTTON_N,
   input wire logic CONTROL_TEST_PUSHBUTTON_N,
   input wire logic REMOTE_TEST_N,
   input wire logic CLEAR_LINE_N,
   input wire logic [1:0] WORD_COUNTER,
   input wire logic SHAPED_PULSE_N,
   input wire logic [23:0] REMOTE_LED_N,
   input wire logic [23:0] CONTROL_LED_N,
   input wire logic [23:0] ALARM_DRIVE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   property p_step;
      $fell(SHAPED_PULSE_N) |-> WORD_COUNTER == $past(WORD_COUNTER) + 2'h1;
   endproperty
   a_step: assert property (p_step) else $error("count step");
   property p_width;
      $fell(SHAPED_PULSE_N) |-> !SHAPED_PULSE_N [*4] ##1 SHAPED_PULSE_N;
   endproperty
   a_width: assert property (p_width) else $error("pulse width");
   property p_hold;
      $changed(WORD_COUNTER) && $past(RSTN) |-> $fell(SHAPED_PULSE_N);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   property p_clr;
      !CLEAR_PUSHBUTTON_N [*8] |-> !CLEAR_LINE_N;
   endproperty
   a_clr: assert property (p_clr) else $error("clear line");
   property p_ctest;
      !CONTROL_TEST_PUSHBUTTON_N [*8] |-> CONTROL_LED_N == 24'h0 && ALARM_DRIVE == 24'hFFFFFF;
   endproperty
   a_ctest: assert property (p_ctest) else $error("control test");
   property p_alarm;
      ALARM_DRIVE == ~CONTROL_LED_N;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm level");
   property p_rtest;
      !REMOTE_TEST_N [*8] |-> REMOTE_LED_N == 24'h0;
   endproperty
   a_rtest: assert property (p_rtest) else $error("remote test");
   property p_clrset;
      (!CLEAR_LINE_N && REMOTE_TEST_N) [*8] |-> REMOTE_LED_N == 24'hFFFFFF;
   endproperty
   a_clrset: assert property (p_clrset) else $error("clear set");
   c_wrap: cover property ($fell(SHAPED_PULSE_N) && WORD_COUNTER == 2'h0);
   c_clear: cover property ($fell(CLEAR_LINE_N));
   c_test: cover property (CONTROL_LED_N == 24'h0);
endmodule // scs_props
bind scs_scanner scs_props u_props (.*);
`default_nettype wire

// ### verification/scs_host_model.sv
// Far side model: host cycle strobes and control terminal word delivery.
`default_nettype none
module scs_host_model (
   input wire logic clk,
   output logic strobe,
   output logic [5:0] data,
   output logic arr_n,
   output logic sel_lo,
   output logic sel_hi,
   output logic three_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      strobe = 1'b0;
      data = 6'h3F;
      arr_n = 1'b1;
      {sel_hi, sel_lo} = 2'h0;
      three_n = 1'b1;
   end
   task cycle_done_strobe;
      @(posedge clk);
      strobe <= 1'b1;
      repeat (6) @(posedge clk);
      strobe <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   task send(input logic [1:0] g, input logic [5:0] d);
      @(posedge clk);
      {sel_hi, sel_lo} <= g;
      data <= d;
      three_n <= 1'b0;
      repeat (6) @(posedge clk);
      arr_n <= 1'b0;
      repeat (6) @(posedge clk);
      arr_n <= 1'b1;
      three_n <= 1'b1;
      repeat (6) @(posedge clk);
      data <= ~d;
   endtask
endmodule // scs_host_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the status channel scanner.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, clr_n = 1, ct_n = 1, rt_n = 1, we = 0, re = 0;
   logic [23:0] ch_n = 24'hFFFFFF, lat, ctl;
   logic [7:0] addr = 8'h00;
   logic [31:0] wd = 32'h0;
   wire [31:0] rdata;
   wire [23:0] rled, cled, alarm;
   wire [5:0] gd, rx;
   wire [1:0] wc;
   wire cl_n, stb, arr_n, sl, sh, t3_n;
   int fail_count = 0, cmp_count = 0;
   always #4 clk = ~clk;
   scs_host_model host (.clk(clk), .strobe(stb), .data(rx), .arr_n(arr_n), .sel_lo(sl),
      .sel_hi(sh), .three_n(t3_n));
   scs_scanner uut (.REF_CLK(clk), .RSTN(rstn), .CHAN_IN_N(ch_n), .CLEAR_PUSHBUTTON_N(clr_n),
      .CONTROL_TEST_PUSHBUTTON_N(ct_n), .REMOTE_TEST_N(rt_n), .CYCLE_DONE_STROBE(stb),
      .RX_GROUP_DATA(rx), .WORD_ARRIVAL_STROBE_N(arr_n), .WORD_SELECT_LOW(sl),
      .WORD_SELECT_HIGH(sh), .THREE_WORDS_RECEIVED_N(t3_n), .CLEAR_LINE_N(cl_n),
      .GROUP_DATA_BITS(gd), .WORD_COUNTER(wc), .SHAPED_PULSE_N(), .REMOTE_LED_N(rled),
      .CONTROL_LED_N(cled), .ALARM_DRIVE(alarm), .REG_ADDR(addr), .REG_WDATA(wd),
      .REG_WRITE(we), .REG_READ(re), .REG_RDATA(rdata));
   task test_done;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task t_reset;
      chk(cl_n, 1'h1);
      chk(gd, 6'h3F);
      chk(wc, 2'h0);
      chk(rled, 24'hFFFFFF);
      chk(alarm, 24'h0);
      rd(8'h00, 32'h0);
   endtask
   task t_latch;
      @(posedge clk) ch_n <= 24'hF7FF7F;
      cyc(6);
      @(posedge clk) ch_n <= 24'hFFFFFF;
      cyc(10);
      lat = 24'hF7FF7F;
      chk(rled, lat);
      rd(8'h04, {8'h0, lat});
   endtask
   task t_scan;
      for (int k = 1; k <= 4; k++) begin
         host.cycle_done_strobe;
         cyc(2);
         chk(wc, k[1:0]);
         chk(gd, (lat >> (6 * (k % 4))) & 24'h3F);
      end
   endtask
   task t_clear;
      @(posedge clk) ch_n <= 24'hFFFFFE;
      clr_n <= 1'b0;
      cyc(12);
      chk(cl_n, 1'h0);
      chk(rled, 24'hFFFFFF);
      @(posedge clk) clr_n <= 1'b1;
      cyc(12);
      lat = 24'hFFFFFE;
      chk(rled, lat);
      @(posedge clk) ch_n <= 24'hFFFFFF;
      cyc(8);
   endtask
   task t_nonlat;
      wr(8'h00, 32'h2);
      rd(8'h00, 32'h2);
      wr(8'h04, 32'h0);
      rd(8'h04, {8'h0, lat});
      rd(8'h0C, 32'h3C);
      @(posedge clk) ch_n <= 24'hFFFFFD;
      cyc(10);
      chk(gd, 6'h3C);
      @(posedge clk) ch_n <= 24'hFFFFFF;
      cyc(10);
      chk(gd, 6'h3E);
      wr(8'h00, 32'h0);
      lat = 24'hFFFFFC;
      rd(8'h04, {8'h0, lat});
   endtask
   task t_ctl;
      host.send(2'h2, 6'h2A);
      cyc(2);
      ctl = 24'hFFFFFF;
      ctl[17:12] = 6'h2A;
      chk(cled, ctl);
      @(posedge clk) ct_n <= 1'b0;
      cyc(10);
      chk(alarm, 24'hFFFFFF);
      host.send(2'h1, 6'h3F);
      ct_n <= 1'b1;
      cyc(10);
      chk(cled, 24'h0);
      ctl = 24'h0;
      for (int g = 0; g < 4; g++) begin
         host.send(g[1:0], 6'h15 + g[5:0]);
         cyc(2);
         ctl[6 * g +: 6] = 6'h15 + g[5:0];
         chk(cled, ctl);
      end
      chk(alarm, {8'h00, ~ctl});
      rd(8'h08, {8'h0, ctl});
   endtask
   task t_rtest;
      @(posedge clk) rt_n <= 1'b0;
      cyc(10);
      chk(rled, 24'h0);
      chk(cled, ctl);
      @(posedge clk) rt_n <= 1'b1;
      cyc(10);
      chk(rled, lat);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      cyc(6);
      t_reset;
      t_latch;
      t_scan;
      t_clear;
      t_nonlat;
      t_ctl;
      t_rtest;
      test_done;
   end
   initial begin
      #200000;
      fail_count++;
      test_done;
   end
endmodule // tb_top
`default_nettype wire
